// [logic/hb_regs_cfg.svh]
`ifndef HB_REGS_CFG_SVH
`define HB_REGS_CFG_SVH
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define HB_OFS_CMD 8'h08
`define HB_OFS_PIN 8'h09
`define HB_OFS_CFG1 8'h0A
`define HB_OFS_CFG2 8'h0B
`define HB_OFS_CFG3 8'h0C
`define HB_OFS_CFG4 8'h0D
// ----------------------------------------------------------------
// reset values and implemented-bit masks
// ----------------------------------------------------------------
`define HB_RST_CMD 8'h09
`define HB_RST_PIN 8'h0C
`define HB_RST_CFG1 8'h10
`define HB_RST_CFG2 8'h00
`define HB_RST_CFG3 8'h40
`define HB_RST_CFG4 8'h04
`define HB_MASK_CMD 8'h1B
`define HB_MASK_PIN 8'h0F
`define HB_MASK_CFG1 8'hFF
`define HB_MASK_CFG2 8'hE7
`define HB_MASK_CFG3 8'hDF
`define HB_MASK_CFG4 8'hDF
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define HB_BIT_CLR 7
`define HB_PIN_LOCK_HI 4
`define HB_PIN_LOCK_LO 3
`define HB_CFG_LOCK_HI 1
`define HB_CFG_LOCK_LO 0
`define HB_BIT_REG_DRV_OFF 3
`define HB_BIT_REG_INPUT 0
`define HB_BIT_OLA_EN 7
`define HB_OV_SEL_HI 6
`define HB_OV_SEL_LO 5
`define HB_BIT_SPREAD_SPECTRUM_DISABLE 4
`define HB_BIT_OC_REACT 3
`define HB_BIT_OT_REACT 2
`define HB_BIT_OV_REACT 1
`define HB_BIT_OL_REACT 0
`define HB_DIAG_HI 6
`define HB_DIAG_LO 5
`define HB_ITRIP_HI 2
`define HB_ITRIP_LO 0
`define HB_REGULATION_OFF_TIME_HI 7
`define HB_REGULATION_OFF_TIME_LO 6
`define HB_SR_HI 4
`define HB_SR_LO 2
`define HB_TOCP_HI 7
`define HB_TOCP_LO 6
`define HB_OCP_HI 4
`define HB_OCP_LO 3
`define HB_BIT_DRV_SEL 2
`define HB_BIT_IN_SEL 0
`define HB_LOCK_PATTERN 2'h2
// ----------------------------------------------------------------
// decoded settings
// ----------------------------------------------------------------
`define HB_REGULATION_OFF_TIME_US_0 6'h14
`define HB_REGULATION_OFF_TIME_US_1 6'h1E
`define HB_REGULATION_OFF_TIME_US_2 6'h28
`define HB_REGULATION_OFF_TIME_US_3 6'h32
`define HB_TOCP_NS_0 13'h1770
`define HB_TOCP_NS_1 13'h0BB8
`define HB_TOCP_NS_2 13'h05DC
`define HB_TOCP_NS_3 13'h00C8
`define HB_OCP_PCT_FULL 7'h64
`define HB_OCP_PCT_75 7'h4B
`define HB_OCP_PCT_50 7'h32
`endif

// [logic/hb_regs_pkg.sv]
package hb_regs_pkg;
	// overvoltage trip selection
	typedef enum logic [1:0] {
		OV_ABOVE_35V,
		OV_ABOVE_28V,
		OV_ABOVE_18V,
		OV_DISABLED
	} ov_level_t;
	typedef logic [7:0] reg_byte_t;
endpackage : hb_regs_pkg

// [logic/half_bridge_control_config_regs.sv]
`include "hb_regs_cfg.svh"
// Operation
// (R1) writing one to fault-clear clears all faults and releases the fault output
// (R2) pin-override lock pattern 10 unlocks override, others lock; resets locked
// (R3) config lock pattern 10 locks config registers, others unlock; resets unlocked
// (R4) register drive-off bit stands in for the drive-off pin when unlocked; resets one
// (R5) register input bit stands in for the input pin when unlocked; resets zero
// (R6) drive-off combine select: zero ORs pin and bit, one ANDs them
// (R7) input combine select: zero ORs pin and bit, one ANDs them
// (R8) active open-load enable turns on detection in the active state
// (R9) independent mode with low-side load keeps active open-load detection off
// (R10) overvoltage select: 35 V, 28 V, 18 V, or diagnostic disabled
// (R11) spread-spectrum disable resets one; zero enables clock modulation
// (R12) four reaction bits pick retry when one, latched shutdown when zero
// (R13) two-bit load-type field, read/write, resets zero
// (R14) three-bit current-trip level field, read/write, resets zero
// (R15) off-time field picks 20, 30, 40 or 50 us; resets to 30 us
// (R16) three-bit slew-rate field, read/write, resets zero
// (R17) overcurrent filter picks 6, 3, 1.5 or about 0.2 us
// (R18) overcurrent threshold: 00 full, 10 seventy-five, 01 and 11 fifty percent
// (R19) unimplemented bits ignore writes and read zero
// (R20) spare bits store and read back written values without effect
// (R21) locked config registers ignore writes; command register stays writable
// (R22) locked override: drive-off and input follow their pins alone
// (R23) fault-clear is a single-cycle pulse, never held
module half_bridge_control_config_regs (
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic WR_EN,
	input wire logic [7:0] WR_ADDR,
	input wire logic [7:0] WR_DATA,
	input wire logic RD_EN,
	input wire logic [7:0] RD_ADDR,
	output logic [7:0] RD_DATA,
	input wire logic DRIVE_OFF_PIN,
	input wire logic INPUT_PIN,
	input wire logic FAULT_EVENT,
	input wire logic ACTIVE_STATE,
	input wire logic INDEPENDENT_MODE,
	input wire logic LOW_SIDE_LOAD,
	output logic FAULT_CLEAR,
	output logic FAULT_OUT_N,
	output logic DRIVE_OFF,
	output logic INPUT_LEVEL,
	output logic OPEN_LOAD_ACTIVE_EN,
	output hb_regs_pkg::ov_level_t OV_LEVEL,
	output logic OV_DETECT_EN,
	output logic SPREAD_SPECTRUM_EN,
	output logic OC_RETRY,
	output logic OT_RETRY,
	output logic OV_RETRY,
	output logic OL_RETRY,
	output logic [1:0] LOAD_TYPE,
	output logic [2:0] TRIP_LEVEL,
	output logic [5:0] OFF_TIME_US,
	output logic [2:0] SLEW_RATE,
	output logic [12:0] OC_FILTER_NS,
	output logic [6:0] OC_THRESHOLD_PCT
);
	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	hb_regs_pkg::reg_byte_t command_ctrl;
	hb_regs_pkg::reg_byte_t pin_override;
	hb_regs_pkg::reg_byte_t protection_config;
	hb_regs_pkg::reg_byte_t load_trip_config;
	hb_regs_pkg::reg_byte_t regulation_slew_config;
	hb_regs_pkg::reg_byte_t overcurrent_pin_config;
	logic drv_meta, drv_sync, in_meta, in_sync;
	logic fault_held;
	logic pin_unlocked, cfg_locked;
	logic wr_cmd, wr_pin;

	// off-time selection to microseconds
	function automatic logic [5:0] off_time_us(input logic [1:0] sel);
		unique case (sel)
			2'h0: off_time_us = `HB_REGULATION_OFF_TIME_US_0;
			2'h1: off_time_us = `HB_REGULATION_OFF_TIME_US_1;
			2'h2: off_time_us = `HB_REGULATION_OFF_TIME_US_2;
			2'h3: off_time_us = `HB_REGULATION_OFF_TIME_US_3;
		endcase
	endfunction : off_time_us

	// overcurrent filter selection to nanoseconds
	function automatic logic [12:0] oc_filter_ns(input logic [1:0] sel);
		unique case (sel)
			2'h0: oc_filter_ns = `HB_TOCP_NS_0;
			2'h1: oc_filter_ns = `HB_TOCP_NS_1;
			2'h2: oc_filter_ns = `HB_TOCP_NS_2;
			2'h3: oc_filter_ns = `HB_TOCP_NS_3;
		endcase
	endfunction : oc_filter_ns

	// overcurrent threshold; both odd codes mean half
	function automatic logic [6:0] oc_pct(input logic [1:0] sel);
		unique case (sel)
			2'h0: oc_pct = `HB_OCP_PCT_FULL;
			2'h2: oc_pct = `HB_OCP_PCT_75;
			2'h1, 2'h3: oc_pct = `HB_OCP_PCT_50;
		endcase
	endfunction : oc_pct

	// merge a pin with its register bit; AND when sel is one
	function automatic logic merge(input logic unl, input logic sel, input logic pin,
		input logic bitv);
		if (!unl) begin
			merge = pin;
		end else if (sel) begin
			merge = pin & bitv;
		end else begin
			merge = pin | bitv;
		end
	endfunction : merge

	assign pin_unlocked = (command_ctrl[`HB_PIN_LOCK_HI:`HB_PIN_LOCK_LO] == `HB_LOCK_PATTERN); // see (R2)
	assign cfg_locked = (command_ctrl[`HB_CFG_LOCK_HI:`HB_CFG_LOCK_LO] == `HB_LOCK_PATTERN); // see (R3)
	assign wr_cmd = WR_EN && (WR_ADDR == `HB_OFS_CMD);
	assign wr_pin = WR_EN && (WR_ADDR == `HB_OFS_PIN);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	// pins are asynchronous; drive-off resets high so the bridge starts off
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			drv_meta <= 1'b1;
			drv_sync <= 1'b1;
			in_meta <= 1'b0;
			in_sync <= 1'b0;
		end else begin
			drv_meta <= DRIVE_OFF_PIN;
			drv_sync <= drv_meta;
			in_meta <= INPUT_PIN;
			in_sync <= in_meta;
		end
	end

	// ----------------------------------------------------------------
	// command register and fault clear
	// ----------------------------------------------------------------
	// clear bit is never stored, so it always reads zero
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			command_ctrl <= `HB_RST_CMD;
		end else if (wr_cmd) begin
			command_ctrl <= WR_DATA & `HB_MASK_CMD; // see (R19) (R21)
		end
	end

	// one-cycle pulse per write
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			FAULT_CLEAR <= 1'b0;
		end else begin
			FAULT_CLEAR <= wr_cmd && WR_DATA[`HB_BIT_CLR]; // see (R1) (R23)
		end
	end

	// a fault arriving with the clear is kept: set wins
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			fault_held <= 1'b0;
		end else begin
			fault_held <= FAULT_EVENT | (fault_held & ~FAULT_CLEAR); // see (R1)
		end
	end
	assign FAULT_OUT_N = ~fault_held;

	// ----------------------------------------------------------------
	// override and configuration registers
	// ----------------------------------------------------------------
	// override register only accepts writes while unlocked
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			pin_override <= `HB_RST_PIN; // see (R4) (R5)
		end else if (wr_pin && pin_unlocked) begin
			pin_override <= WR_DATA & `HB_MASK_PIN; // see (R19) (R20)
		end
	end

	// lock blocks all four config registers together
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			protection_config <= `HB_RST_CFG1;
			load_trip_config <= `HB_RST_CFG2;
			regulation_slew_config <= `HB_RST_CFG3; // see (R15)
			overcurrent_pin_config <= `HB_RST_CFG4; // see (R6) (R7)
		end else if (WR_EN && !cfg_locked) begin // see (R21)
			unique case (WR_ADDR)
				`HB_OFS_CFG1: protection_config <= WR_DATA & `HB_MASK_CFG1;
				`HB_OFS_CFG2: load_trip_config <= WR_DATA & `HB_MASK_CFG2; // see (R19) (R20)
				`HB_OFS_CFG3: regulation_slew_config <= WR_DATA & `HB_MASK_CFG3;
				`HB_OFS_CFG4: overcurrent_pin_config <= WR_DATA & `HB_MASK_CFG4;
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// read port
	// ----------------------------------------------------------------
	// unmapped addresses read zero
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			RD_DATA <= 8'h00;
		end else if (RD_EN) begin
			unique case (RD_ADDR)
				`HB_OFS_CMD: RD_DATA <= command_ctrl;
				`HB_OFS_PIN: RD_DATA <= pin_override;
				`HB_OFS_CFG1: RD_DATA <= protection_config;
				`HB_OFS_CFG2: RD_DATA <= load_trip_config;
				`HB_OFS_CFG3: RD_DATA <= regulation_slew_config;
				`HB_OFS_CFG4: RD_DATA <= overcurrent_pin_config;
				default: RD_DATA <= 8'h00; // see (R19)
			endcase
		end
	end

	// ----------------------------------------------------------------
	// decoded controls
	// ----------------------------------------------------------------
	// registered so consumers see glitch-free settings, at one cycle of lag
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			DRIVE_OFF <= 1'b1;
			INPUT_LEVEL <= 1'b0;
			OPEN_LOAD_ACTIVE_EN <= 1'b0;
			OV_LEVEL <= hb_regs_pkg::OV_ABOVE_35V;
			OV_DETECT_EN <= 1'b1;
			SPREAD_SPECTRUM_EN <= 1'b0;
			OC_RETRY <= 1'b0;
			OT_RETRY <= 1'b0;
			OV_RETRY <= 1'b0;
			OL_RETRY <= 1'b0;
			LOAD_TYPE <= 2'h0;
			TRIP_LEVEL <= 3'h0;
			OFF_TIME_US <= `HB_REGULATION_OFF_TIME_US_1;
			SLEW_RATE <= 3'h0;
			OC_FILTER_NS <= `HB_TOCP_NS_0;
			OC_THRESHOLD_PCT <= `HB_OCP_PCT_FULL;
		end else begin
			DRIVE_OFF <= merge(pin_unlocked, overcurrent_pin_config[`HB_BIT_DRV_SEL],
				drv_sync, pin_override[`HB_BIT_REG_DRV_OFF]); // see (R4) (R6) (R22)
			INPUT_LEVEL <= merge(pin_unlocked, overcurrent_pin_config[`HB_BIT_IN_SEL],
				in_sync, pin_override[`HB_BIT_REG_INPUT]); // see (R5) (R7) (R22)
			OPEN_LOAD_ACTIVE_EN <= protection_config[`HB_BIT_OLA_EN] && ACTIVE_STATE
				&& !(INDEPENDENT_MODE && LOW_SIDE_LOAD); // see (R8) (R9)
			OV_LEVEL <= hb_regs_pkg::ov_level_t'(
				protection_config[`HB_OV_SEL_HI:`HB_OV_SEL_LO]); // see (R10)
			OV_DETECT_EN <= (protection_config[`HB_OV_SEL_HI:`HB_OV_SEL_LO] != 2'h3);
			SPREAD_SPECTRUM_EN <= !protection_config[`HB_BIT_SPREAD_SPECTRUM_DISABLE]; // see (R11)
			OC_RETRY <= protection_config[`HB_BIT_OC_REACT]; // see (R12)
			OT_RETRY <= protection_config[`HB_BIT_OT_REACT];
			OV_RETRY <= protection_config[`HB_BIT_OV_REACT];
			OL_RETRY <= protection_config[`HB_BIT_OL_REACT];
			LOAD_TYPE <= load_trip_config[`HB_DIAG_HI:`HB_DIAG_LO]; // see (R13)
			TRIP_LEVEL <= load_trip_config[`HB_ITRIP_HI:`HB_ITRIP_LO]; // see (R14)
			OFF_TIME_US <= off_time_us(regulation_slew_config[`HB_REGULATION_OFF_TIME_HI:`HB_REGULATION_OFF_TIME_LO]); // see (R15)
			SLEW_RATE <= regulation_slew_config[`HB_SR_HI:`HB_SR_LO]; // see (R16)
			OC_FILTER_NS <= oc_filter_ns(overcurrent_pin_config[`HB_TOCP_HI:`HB_TOCP_LO]); // see (R17)
			OC_THRESHOLD_PCT <= oc_pct(overcurrent_pin_config[`HB_OCP_HI:`HB_OCP_LO]); // see (R18)
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	clear_pulse_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // see (R23)
		FAULT_CLEAR |-> $past(wr_cmd) && $past(WR_DATA[`HB_BIT_CLR]))
		else $error("fault clear without a clear write");
	fault_release_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // see (R1)
		wr_cmd && WR_DATA[`HB_BIT_CLR] && !FAULT_EVENT ##1 !FAULT_EVENT |=> FAULT_OUT_N)
		else $error("fault output not released by clear");
	pin_locked_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // see (R22)
		!pin_unlocked |=> DRIVE_OFF == $past(drv_sync) && INPUT_LEVEL == $past(in_sync))
		else $error("locked override does not follow pins");
	drive_and_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // see (R6)
		pin_unlocked && overcurrent_pin_config[`HB_BIT_DRV_SEL]
		&& !pin_override[`HB_BIT_REG_DRV_OFF] |=> !DRIVE_OFF)
		else $error("drive-off AND combine wrong");
	input_or_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // see (R7)
		pin_unlocked && !overcurrent_pin_config[`HB_BIT_IN_SEL]
		&& pin_override[`HB_BIT_REG_INPUT] |=> INPUT_LEVEL)
		else $error("input OR combine wrong");
	cfg_lock_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // see (R21)
		cfg_locked && WR_EN && WR_ADDR == `HB_OFS_CFG1 |=> $stable(protection_config))
		else $error("locked config register changed");
	ola_gate_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // see (R9)
		INDEPENDENT_MODE && LOW_SIDE_LOAD |=> !OPEN_LOAD_ACTIVE_EN)
		else $error("open-load enabled for low-side load");
	ov_off_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // see (R10)
		protection_config[`HB_OV_SEL_HI:`HB_OV_SEL_LO] == 2'h3 |=> !OV_DETECT_EN)
		else $error("overvoltage not disabled");
	unmapped_zero_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // see (R19)
		RD_EN && (RD_ADDR < `HB_OFS_CMD || RD_ADDR > `HB_OFS_CFG4) |=> RD_DATA == 8'h00)
		else $error("unmapped read not zero");
	spare_back_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // see (R20)
		WR_EN && WR_ADDR == `HB_OFS_CFG3 && !cfg_locked |=>
		regulation_slew_config[1:0] == $past(WR_DATA[1:0]) && !regulation_slew_config[5])
		else $error("spare bits not stored");
	reset_value_a: assert property (@(posedge SYS_CLK) // see (R2) (R3)
		!RST_N |=> command_ctrl == `HB_RST_CMD && pin_override == `HB_RST_PIN)
		else $error("command reset value wrong");
	clear_seen_c: cover property (@(posedge SYS_CLK) disable iff (!RST_N)
		!FAULT_OUT_N ##1 FAULT_CLEAR ##1 FAULT_OUT_N);
	unlock_drive_c: cover property (@(posedge SYS_CLK) disable iff (!RST_N)
		pin_unlocked && !drv_sync ##1 DRIVE_OFF);
	locked_write_c: cover property (@(posedge SYS_CLK) disable iff (!RST_N)
		cfg_locked && WR_EN && WR_ADDR == 8'h0B);
endmodule : half_bridge_control_config_regs

// [tb/host_ctrl_model.sv]
// ----------------------------------------------------------------
// register controller on the far side of the strobe port
// ----------------------------------------------------------------
module host_ctrl_model (
	input wire logic clk,
	output logic wr_en,
	output logic [7:0] wr_addr,
	output logic [7:0] wr_data,
	output logic rd_en,
	output logic [7:0] rd_addr,
	input wire logic [7:0] rd_data
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle bus starts quiet
	initial begin
		wr_en = 1'b0;
		rd_en = 1'b0;
		wr_addr = 8'h00;
		wr_data = 8'h00;
		rd_addr = 8'h00;
	end
	// released lines show the inverse so stale values never look valid
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr_en <= 1'b1;
		wr_addr <= a;
		wr_data <= d;
		@(posedge clk);
		wr_en <= 1'b0;
		wr_addr <= ~a;
		wr_data <= ~d;
	endtask : wr
	// data is taken 1 ns after the strobe edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		rd_en <= 1'b1;
		rd_addr <= a;
		@(posedge clk);
		rd_en <= 1'b0;
		rd_addr <= ~a;
		#1 d = rd_data;
	endtask : rd
endmodule : host_ctrl_model

// [tb/half_bridge_control_config_regs_tb_top.sv]
`include "hb_regs_cfg.svh"
module half_bridge_control_config_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_n, wr_en, rd_en, dpin, ipin, fev, act, ind, low;
	logic [7:0] wa, wd, ra, rdd, d;
	logic fclr, fout_n, doff, ilev, olen, ovdet, ssc, ocr, otr, ovr, olr;
	hb_regs_pkg::ov_level_t ovl;
	logic [1:0] ltype;
	logic [2:0] trip, slew;
	logic [5:0] regulation_off_time;
	logic [12:0] filt;
	logic [6:0] thr;
	int miscompares, comparisons;
	logic [7:0] ofs [6] = '{`HB_OFS_CMD, `HB_OFS_PIN, `HB_OFS_CFG1, `HB_OFS_CFG2,
		`HB_OFS_CFG3, `HB_OFS_CFG4};
	logic [7:0] rst [6] = '{8'h09, 8'h0C, 8'h10, 8'h00, 8'h40, 8'h04};
	logic [7:0] msk [6] = '{8'h1B, 8'h0F, 8'hFF, 8'hE7, 8'hDF, 8'hDF};
	logic [5:0] e_regulation_off_time [4] = '{6'h14, 6'h1E, 6'h28, 6'h32};
	logic [12:0] e_filt [4] = '{13'h1770, 13'h0BB8, 13'h05DC, 13'h00C8};
	logic [6:0] e_thr [4] = '{7'h64, 7'h32, 7'h4B, 7'h32};

	half_bridge_control_config_regs uut (.SYS_CLK(clk), .RST_N(rst_n), .WR_EN(wr_en),
		.WR_ADDR(wa), .WR_DATA(wd), .RD_EN(rd_en), .RD_ADDR(ra), .RD_DATA(rdd),
		.DRIVE_OFF_PIN(dpin), .INPUT_PIN(ipin), .FAULT_EVENT(fev), .ACTIVE_STATE(act),
		.INDEPENDENT_MODE(ind), .LOW_SIDE_LOAD(low), .FAULT_CLEAR(fclr),
		.FAULT_OUT_N(fout_n), .DRIVE_OFF(doff), .INPUT_LEVEL(ilev),
		.OPEN_LOAD_ACTIVE_EN(olen), .OV_LEVEL(ovl), .OV_DETECT_EN(ovdet),
		.SPREAD_SPECTRUM_EN(ssc), .OC_RETRY(ocr), .OT_RETRY(otr), .OV_RETRY(ovr),
		.OL_RETRY(olr), .LOAD_TYPE(ltype), .TRIP_LEVEL(trip), .OFF_TIME_US(regulation_off_time),
		.SLEW_RATE(slew), .OC_FILTER_NS(filt), .OC_THRESHOLD_PCT(thr));
	host_ctrl_model host (.clk(clk), .wr_en(wr_en), .wr_addr(wa), .wr_data(wd),
		.rd_en(rd_en), .rd_addr(ra), .rd_data(rdd));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// wide enough for the longest concatenated compare (26 bits)
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : check
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic conclude;
		$display("miscompares=%0d comparisons=%0d", miscompares, comparisons);
		if (miscompares == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : conclude

	// 200 MHz clock and a watchdog so a hang still ends in the report
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		#200us;
		miscompares++;
		conclude();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		{rst_n, dpin, ipin, fev, act, ind, low} = 7'b0100000;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		// reset values, then all-ones to show which bits really store
		for (int i = 0; i < 6; i++) begin
			host.rd(ofs[i], d);
			check(d, rst[i]);
		end
		check({regulation_off_time, filt, thr}, {6'h1E, 13'h1770, 7'h64});
		host.rd(8'h0E, d);
		check(d, 8'h00);
		for (int i = 2; i < 6; i++) begin
			host.wr(ofs[i], 8'hFF);
			host.rd(ofs[i], d);
			check(d, msk[i]);
		end
		check({ocr, otr, ovr, olr, ovdet, ssc}, 6'h3C);
		check({ltype, trip, slew}, 8'hFF);
		host.wr(`HB_OFS_CFG1, 8'h00);
		tick(2);
		check({ocr, otr, ovr, olr, ovdet, ssc}, 6'h03);
		// every code of the decoded selections
		for (int k = 0; k < 4; k++) begin
			host.wr(`HB_OFS_CFG3, 8'(k << 6));
			host.wr(`HB_OFS_CFG4, 8'((k << 6) | (k << 3)));
			host.wr(`HB_OFS_CFG1, 8'(k << 5));
			tick(2);
			check({regulation_off_time, filt, thr}, {e_regulation_off_time[k], e_filt[k], e_thr[k]});
			check({ovl, ovdet}, {2'(k), k != 3});
		end
		// config lock freezes 0A-0D; the all-ones value from above must survive a zero write
		host.wr(`HB_OFS_CMD, 8'h0A);
		host.wr(`HB_OFS_CFG2, 8'h00);
		host.rd(`HB_OFS_CFG2, d);
		check(d, 8'hE7);
		host.wr(`HB_OFS_CMD, 8'h0B);
		host.wr(`HB_OFS_CFG2, 8'h25);
		host.rd(`HB_OFS_CFG2, d);
		check(d, 8'h25);
		// fault held, then one clear pulse releases it
		@(posedge clk);
		fev <= 1'b1;
		@(posedge clk);
		fev <= 1'b0;
		tick(1);
		check(fout_n, 1'b0);
		// the clear pulse stands only for the cycle after the strobe edge
		host.wr(`HB_OFS_CMD, 8'h89);
		#1;
		check(fclr, 1'b1);
		tick(1);
		check({fclr, fout_n}, 2'b01);
		host.rd(`HB_OFS_CMD, d);
		check(d, 8'h09);
		// locked override: writes dropped, outputs follow pins alone
		host.wr(`HB_OFS_PIN, 8'h01);
		host.rd(`HB_OFS_PIN, d);
		check(d, 8'h0C);
		// pins chosen against the stored bits so a leaking merge would show
		host.wr(`HB_OFS_CFG4, 8'h01);
		@(posedge clk);
		dpin <= 1'b0;
		ipin <= 1'b1;
		tick(4);
		check({doff, ilev}, 2'b01);
		host.wr(`HB_OFS_CMD, 8'h11);
		for (int v = 0; v < 8; v++) begin
			host.wr(`HB_OFS_PIN, {4'h0, v[1], 2'b10, v[1]});
			host.wr(`HB_OFS_CFG4, {5'h00, v[2], 1'b0, v[2]});
			@(posedge clk);
			dpin <= v[0];
			ipin <= v[0];
			tick(4);
			check({doff, ilev}, {2{v[2] ? v[0] & v[1] : v[0] | v[1]}});
		end
		// open-load detection gated by state and load type
		host.wr(`HB_OFS_CFG1, 8'h90);
		for (int m = 0; m < 4; m++) begin
			@(posedge clk);
			act <= 1'b1;
			{ind, low} <= 2'(m);
			tick(2);
			check(olen, m != 3);
		end
		// outside the active state detection stays off even with the bit set
		@(posedge clk);
		act <= 1'b0;
		{ind, low} <= 2'b00;
		tick(2);
		check(olen, 1'b0);
		conclude();
	end
endmodule : half_bridge_control_config_regs_tb_top
